// >>> verilog/sbc_params.svh
// constants for the sensorless commutation controller
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

`define SBC_CLK_HZ          100000000
`define SBC_SC_FILTER_CLOCK_MIN_HZ    250000
`define SBC_SC_FILTER_CLOCK_MAX_HZ    4000000
// filter clock divider: half period in system cycles, allowed range from the limits
// the minimum rounds up, otherwise a truncated divider would overshoot 4 MHz
`define SBC_SCDIV_MIN       ((`SBC_CLK_HZ + 2 * `SBC_SC_FILTER_CLOCK_MAX_HZ - 1) / (2 * `SBC_SC_FILTER_CLOCK_MAX_HZ))
`define SBC_SCDIV_MAX       (`SBC_CLK_HZ / (2 * `SBC_SC_FILTER_CLOCK_MIN_HZ))
`define SBC_SCDIV_RST       16'h0028
// chopper period in system cycles (20 kHz default)
`define SBC_CHOP_PER_RST    16'h1388
`define SBC_DUTY_MIN_RST    8'h33
`define SBC_DUTY_MAX_RST    8'he6
`define SBC_DUTY_START_RST  8'h66
// duty is in 1/256 of the period; open time at least 5 %
`define SBC_DUTY_CEIL       8'hf2
`define SBC_STEP_START_RST  24'h0f4240
`define SBC_STEP_MIN_RST    24'h00c350
`define SBC_ACCEL_RST       24'h000100
`define SBC_HAND_RST        24'h01d4c0

`endif

// >>> verilog/sbc_pkg.sv
// types for the sensorless commutation controller
package sbc_pkg;
  typedef enum logic [1:0] {
    SBC_IDLE   = 2'b00,
    SBC_FORCED = 2'b01,
    SBC_FBACK  = 2'b10
  } sbc_mode_type;

  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } sbc_gate_type;

  typedef struct packed {
    logic [15:0] chop_period;
    logic [7:0]  duty;
    logic [7:0]  duty_min;
    logic [7:0]  duty_max;
  } sbc_chop_cfg_type;
endpackage : sbc_pkg

// >>> verilog/sbc_sc_filter_clock_gen.sv
// switched-capacitor filter clock generator
`timescale 1ns/100ps
`default_nettype none
`include "sbc_params.svh"
module sbc_sc_filter_clock_gen (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic [15:0] i_half_div,
  output logic             o_sc_filter_clock
);
  logic [15:0] half_lim;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        clk_reg;
  logic        clk_next;

  // clamping keeps the filter clock between 250 kHz and 4 MHz whatever is asked
  always_comb begin
    half_lim = i_half_div;
    if (i_half_div < 16'(`SBC_SCDIV_MIN)) begin
      half_lim = 16'(`SBC_SCDIV_MIN);
    end else if (i_half_div > 16'(`SBC_SCDIV_MAX)) begin
      half_lim = 16'(`SBC_SCDIV_MAX);
    end
    cnt_next = cnt_reg + 16'h0001;
    clk_next = clk_reg;
    if (cnt_reg + 16'h0001 >= half_lim) begin
      cnt_next = 16'h0000;
      clk_next = ~clk_reg;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt_reg <= 16'h0000;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end

  assign o_sc_filter_clock = clk_reg;

  a_sc_filter_clock_half_max: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $changed(clk_reg) |-> ##1 (!$changed(clk_reg) [*1])
  ) else $error("filter clock toggled too fast");
endmodule : sbc_sc_filter_clock_gen
`default_nettype wire

// >>> verilog/sbc_chopper.sv
// shared chopper pwm with clamped duty
`timescale 1ns/100ps
`default_nettype none
`include "sbc_params.svh"
module sbc_chopper (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_sys_rst,
  input  wire sbc_pkg::sbc_chop_cfg_type i_cfg,
  output logic                           o_chop,
  output logic                           o_period_start
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0]  duty_reg;
  logic [7:0]  duty_next;
  logic [7:0]  lo_b;
  logic [7:0]  hi_b;
  logic [23:0] on_cycles;
  logic        chop_reg;
  logic        chop_next;

  // duty is latched once per period so a mid-period change cannot shorten the open time
  always_comb begin
    lo_b = i_cfg.duty_min;
    hi_b = (i_cfg.duty_max > `SBC_DUTY_CEIL) ? `SBC_DUTY_CEIL : i_cfg.duty_max;
    duty_next = duty_reg;
    cnt_next = cnt_reg + 16'h0001;
    if (cnt_reg + 16'h0001 >= i_cfg.chop_period) begin
      cnt_next = 16'h0000;
      if (i_cfg.duty < lo_b) begin
        duty_next = lo_b;
      end else if (i_cfg.duty > hi_b) begin
        duty_next = hi_b;
      end else begin
        duty_next = i_cfg.duty;
      end
    end
    on_cycles = 24'(({8'h00, i_cfg.chop_period} * {16'h0000, duty_reg}) >> 8);
    chop_next = ({8'h00, cnt_next} < on_cycles);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt_reg  <= 16'h0000;
      duty_reg <= `SBC_DUTY_MIN_RST;
      chop_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      duty_reg <= duty_next;
      chop_reg <= chop_next;
    end
  end

  assign o_chop         = chop_reg;
  assign o_period_start = (cnt_reg == 16'h0000);

  a_chop_open_end: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (cnt_reg + 16'h0001 == i_cfg.chop_period) && (i_cfg.chop_period >= 16'h0020)
      |-> !chop_reg
  ) else $error("coils not open at end of chopper period");
  a_duty_in_range: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ##1 (duty_reg >= lo_b || lo_b > hi_b) && (duty_reg <= `SBC_DUTY_CEIL)
  ) else $error("latched duty outside limits");
endmodule : sbc_chopper
`default_nettype wire

// >>> verilog/sbc_ctrl.sv
// sensorless block commutation controller: forced start, hall feedback, fallback
`timescale 1ns/100ps
`default_nettype none
`include "sbc_params.svh"
module sbc_ctrl (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic        i_run,
  input  wire logic        i_dir_rev,
  input  wire logic        i_restart_on_err,
  input  wire logic [15:0] i_sc_half_div,
  input  wire logic [15:0] i_chop_period,
  input  wire logic [7:0]  i_duty,
  input  wire logic [7:0]  i_duty_min,
  input  wire logic [7:0]  i_duty_max,
  input  wire logic [7:0]  i_duty_start,
  input  wire logic [23:0] i_step_start,
  input  wire logic [23:0] i_step_min,
  input  wire logic [23:0] i_accel,
  input  wire logic [23:0] i_hand_step,
  input  wire logic [2:0]  i_emulated_hall_out,
  output logic             o_sc_filter_clock,
  output logic [2:0]       o_gate_hi,
  output logic [2:0]       o_gate_lo,
  output logic [1:0]       o_mode,
  output logic             o_seq_err,
  output logic [23:0]      o_speed_period,
  output logic             o_dir_meas_rev,
  output logic             o_hall_valid
);
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  sbc_pkg::sbc_mode_type     mode_reg;
  sbc_pkg::sbc_mode_type     mode_next;
  sbc_pkg::sbc_chop_cfg_type chop_cfg;
  sbc_pkg::sbc_gate_type     gate_reg;
  sbc_pkg::sbc_gate_type     gate_next;
  logic [2:0]  hall_s1_reg;
  logic [2:0]  hall_s2_reg;
  logic [2:0]  hall_prev_reg;
  logic [2:0]  hall_prev_next;
  logic [2:0]  step_reg;
  logic [2:0]  step_next;
  logic [23:0] per_reg;
  logic [23:0] per_next;
  logic [23:0] tmr_reg;
  logic [23:0] tmr_next;
  logic [23:0] meas_reg;
  logic [23:0] meas_next;
  logic [23:0] spd_reg;
  logic [23:0] spd_next;
  logic        dir_reg;
  logic        dir_next;
  logic        valid_reg;
  logic        valid_next;
  logic        err_reg;
  logic        err_next;
  logic        chop;
  logic        hall_chg;
  logic        hall_bad;
  logic        hall_fwd;
  logic        hall_rev;
  logic [2:0]  hall_pos;
  logic [2:0]  prev_pos;
  logic [2:0]  adv_pos;
  logic [2:0]  back_pos;

  // ---------------------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------------------
  sbc_sc_filter_clock_gen u_sc_filter_clock (
    .i_clk_sys         (i_clk_sys),
    .i_sys_rst         (i_sys_rst),
    .i_half_div        (i_sc_half_div),
    .o_sc_filter_clock (o_sc_filter_clock)
  );

  // the start-up duty holds current high enough to turn the load blind
  always_comb begin
    chop_cfg.chop_period = i_chop_period;
    chop_cfg.duty_min    = i_duty_min;
    chop_cfg.duty_max    = i_duty_max;
    chop_cfg.duty        = (mode_reg == sbc_pkg::SBC_FORCED) ? i_duty_start : i_duty;
  end

  sbc_chopper u_chop (
    .i_clk_sys      (i_clk_sys),
    .i_sys_rst      (i_sys_rst),
    .i_cfg          (chop_cfg),
    .o_chop         (chop),
    .o_period_start ()
  );

  // ---------------------------------------------------------------------------
  // hall input synchroniser and table lookup
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hall_s1_reg <= 3'h0;
      hall_s2_reg <= 3'h0;
    end else begin
      hall_s1_reg <= i_emulated_hall_out;
      hall_s2_reg <= hall_s1_reg;
    end
  end

  // hall code to table position; 0 and 7 map to an illegal marker
  function automatic logic [2:0] hall_to_pos(input logic [2:0] h);
    logic [2:0] p;
    p = 3'h7;
    unique case (h)
      3'h1: p = 3'h0;
      3'h3: p = 3'h1;
      3'h2: p = 3'h2;
      3'h6: p = 3'h3;
      3'h4: p = 3'h4;
      3'h5: p = 3'h5;
      default: p = 3'h7;
    endcase
    return p;
  endfunction : hall_to_pos

  function automatic logic [2:0] pos_inc(input logic [2:0] p);
    return (p == 3'h5) ? 3'h0 : 3'(p + 3'h1);
  endfunction : pos_inc

  function automatic logic [2:0] pos_dec(input logic [2:0] p);
    return (p == 3'h0) ? 3'h5 : 3'(p - 3'h1);
  endfunction : pos_dec

  // single table: position -> high phase, low phase (one-hot)
  function automatic sbc_pkg::sbc_gate_type pos_to_gate(input logic [2:0] p);
    sbc_pkg::sbc_gate_type g;
    g = '0;
    unique case (p)
      3'h0: g = '{hi: 3'h1, lo: 3'h2};
      3'h1: g = '{hi: 3'h1, lo: 3'h4};
      3'h2: g = '{hi: 3'h2, lo: 3'h4};
      3'h3: g = '{hi: 3'h2, lo: 3'h1};
      3'h4: g = '{hi: 3'h4, lo: 3'h1};
      3'h5: g = '{hi: 3'h4, lo: 3'h2};
      default: g = '0;
    endcase
    return g;
  endfunction : pos_to_gate

  always_comb begin
    hall_pos = hall_to_pos(hall_s2_reg);
    prev_pos = hall_to_pos(hall_prev_reg);
    adv_pos  = pos_inc(prev_pos);
    back_pos = pos_dec(prev_pos);
    hall_chg = (hall_s2_reg != hall_prev_reg);
    hall_fwd = hall_chg && (prev_pos != 3'h7) && (hall_pos == adv_pos);
    hall_rev = hall_chg && (prev_pos != 3'h7) && (hall_pos == back_pos);
    // steady illegal codes count as one event, raised when they appear
    hall_bad = hall_chg && ((hall_pos == 3'h7) ||
               ((prev_pos != 3'h7) && !hall_fwd && !hall_rev));
  end

  // ---------------------------------------------------------------------------
  // commutation state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    mode_next      = mode_reg;
    step_next      = step_reg;
    per_next       = per_reg;
    tmr_next       = tmr_reg + 24'h000001;
    meas_next      = (meas_reg == 24'hffffff) ? meas_reg : meas_reg + 24'h000001;
    spd_next       = spd_reg;
    dir_next       = dir_reg;
    valid_next     = valid_reg;
    err_next       = 1'b0;
    hall_prev_next = hall_s2_reg;
    if (hall_chg && !hall_bad) begin
      spd_next   = meas_reg;
      meas_next  = 24'h000000;
      dir_next   = hall_rev;
      valid_next = 1'b1;
    end
    if (hall_bad) begin
      valid_next = 1'b0;
    end
    unique case (mode_reg)
      sbc_pkg::SBC_IDLE: begin
        tmr_next = 24'h000000;
        per_next = i_step_start;
        if (i_run) begin
          mode_next = sbc_pkg::SBC_FORCED;
        end
      end
      sbc_pkg::SBC_FORCED: begin
        // hall edges are ignored here; stepping is blind like a stepper
        if (tmr_reg >= per_reg) begin
          tmr_next  = 24'h000000;
          step_next = i_dir_rev ? pos_dec(step_reg) : pos_inc(step_reg);
          per_next  = (per_reg > i_step_min + i_accel) ? per_reg - i_accel : i_step_min;
          if (per_reg <= i_hand_step) begin
            mode_next = sbc_pkg::SBC_FBACK;
          end
        end
      end
      sbc_pkg::SBC_FBACK: begin
        if (hall_bad) begin
          err_next = 1'b1;
          mode_next = sbc_pkg::SBC_FORCED;
          tmr_next  = 24'h000000;
          if (i_restart_on_err) begin
            per_next = i_step_start;
          end else begin
            per_next = (spd_reg > i_step_min) ? spd_reg : i_step_min;
          end
        end else if (hall_pos != 3'h7) begin
          step_next = hall_pos;
        end
      end
      default: begin
        mode_next = sbc_pkg::SBC_IDLE;
      end
    endcase
    if (!i_run) begin
      mode_next = sbc_pkg::SBC_IDLE;
    end
    if (mode_reg == sbc_pkg::SBC_IDLE) begin
      gate_next = '0;
    end else begin
      gate_next    = pos_to_gate(step_reg);
      gate_next.hi = gate_next.hi & {3{chop}};
      gate_next.lo = gate_next.lo & {3{chop}};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode_reg      <= sbc_pkg::SBC_IDLE;
      step_reg      <= 3'h0;
      per_reg       <= `SBC_STEP_START_RST;
      tmr_reg       <= 24'h000000;
      meas_reg      <= 24'h000000;
      spd_reg       <= 24'hffffff;
      dir_reg       <= 1'b0;
      valid_reg     <= 1'b0;
      err_reg       <= 1'b0;
      hall_prev_reg <= 3'h0;
      gate_reg      <= '0;
    end else begin
      mode_reg      <= mode_next;
      step_reg      <= step_next;
      per_reg       <= per_next;
      tmr_reg       <= tmr_next;
      meas_reg      <= meas_next;
      spd_reg       <= spd_next;
      dir_reg       <= dir_next;
      valid_reg     <= valid_next;
      err_reg       <= err_next;
      hall_prev_reg <= hall_prev_next;
      gate_reg      <= gate_next;
    end
  end

  assign o_gate_hi      = gate_reg.hi;
  assign o_gate_lo      = gate_reg.lo;
  assign o_mode         = mode_reg;
  assign o_seq_err      = err_reg;
  assign o_speed_period = spd_reg;
  assign o_dir_meas_rev = dir_reg;
  assign o_hall_valid   = valid_reg;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_gate_shared_chop: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode_reg != sbc_pkg::SBC_IDLE) |=> ((o_gate_hi != 3'h0) == $past(chop)) &&
      ((o_gate_lo != 3'h0) == $past(chop))
  ) else $error("high and low side not gated by one chopper");
  a_gate_one_each: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $onehot0(o_gate_hi) && $onehot0(o_gate_lo) && ((o_gate_hi & o_gate_lo) == 3'h0)
  ) else $error("commutation output not a legal table entry");
  a_forced_blind: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode_reg == sbc_pkg::SBC_FORCED) && (tmr_reg < per_reg) && i_run
      |=> $stable(step_reg)
  ) else $error("forced step moved before its period");
  a_handover: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode_reg == sbc_pkg::SBC_FORCED) && (tmr_reg >= per_reg) && (per_reg <= i_hand_step)
      && i_run |=> (mode_reg == sbc_pkg::SBC_FBACK)
  ) else $error("no handover at threshold");
  a_err_fallback: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode_reg == sbc_pkg::SBC_FBACK) && hall_bad && i_run
      |=> (mode_reg == sbc_pkg::SBC_FORCED) && o_seq_err
  ) else $error("sequence error did not fall back to forced mode");
  a_err_event: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode_reg == sbc_pkg::SBC_FBACK) && hall_chg && (hall_s2_reg == 3'h0 ||
      hall_s2_reg == 3'h7) |=> o_seq_err ##1 !o_seq_err [*1]
  ) else $error("illegal hall code not flagged");
  a_speed_meas: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    hall_fwd |=> o_hall_valid && !o_dir_meas_rev && (o_speed_period == $past(meas_reg))
  ) else $error("speed or direction not captured on valid edge");
  a_fb_follows_hall: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode_reg == sbc_pkg::SBC_FBACK) && hall_fwd && i_run |=> (step_reg == $past(hall_pos))
  ) else $error("feedback step does not follow hall");
endmodule : sbc_ctrl
`default_nettype wire

// >>> bench/sbc_drv_model.sv
// behavioural gate driver whose emulated hall outputs follow the energised phase pair
`timescale 1ns/100ps
`default_nettype none
module sbc_drv_model (
  input  wire logic       i_clk_sys,
  input  wire logic [2:0] i_gate_hi,
  input  wire logic [2:0] i_gate_lo,
  input  wire logic       i_inj_en,
  input  wire logic [2:0] i_inj_code,
  output logic      [2:0] o_emulated_hall_out
);
  // ------------------------------------------------------------
  // rotor follows the last driven pair; the hall code runs one step
  // ahead in the sense of rotation, so one table turns both ways
  // ------------------------------------------------------------
  localparam logic [2:0] HALL [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  localparam logic [2:0] HI   [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  localparam logic [2:0] LO   [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  logic [2:0] drv_reg = 3'h0;
  logic [2:0] drv_next;
  logic       rev_reg = 1'b0;
  logic       rev_next;
  logic [2:0] ahead;
  always_comb begin
    drv_next = drv_reg;
    rev_next = rev_reg;
    for (int p = 0; p < 6; p++) begin
      if (i_gate_hi == HI[p] && i_gate_lo == LO[p]) begin
        drv_next = 3'(p);
      end
    end
    if (drv_next == ((drv_reg == 3'h0) ? 3'h5 : 3'(drv_reg - 3'h1))) begin
      rev_next = 1'b1;
    end else if (drv_next == ((drv_reg == 3'h5) ? 3'h0 : 3'(drv_reg + 3'h1))) begin
      rev_next = 1'b0;
    end
    if (rev_reg) begin
      ahead = (drv_reg == 3'h0) ? 3'h5 : 3'(drv_reg - 3'h1);
    end else begin
      ahead = (drv_reg == 3'h5) ? 3'h0 : 3'(drv_reg + 3'h1);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    drv_reg <= drv_next;
    rev_reg <= rev_next;
  end
  // injected codes stand for a motor whose back-emf is lost
  assign o_emulated_hall_out = i_inj_en ? i_inj_code : HALL[ahead];
endmodule : sbc_drv_model
`default_nettype wire

// >>> bench/sensorless_bldc_commutation_control_tb.sv
// self-checking bench for the sensorless commutation controller
`timescale 1ns/100ps
`default_nettype none
module sensorless_bldc_commutation_control_tb;
  // ------------------------------------------------------------
  // stimulus and expectations
  // ------------------------------------------------------------
  localparam int CHOP  = 32;
  localparam int LIMIT = 60000;
  localparam logic [2:0] EHI [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  localparam logic [2:0] ELO [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  typedef struct {logic [15:0] div; int half;} sbc_row_type;
  sbc_row_type rows [5] = '{'{16'h0005, 13}, '{16'h000d, 13}, '{16'h0028, 40},
                            '{16'h00c8, 200}, '{16'h03e8, 200}};
  logic        i_clk_sys        = 1'b0;
  logic        i_sys_rst        = 1'b1;
  logic        i_run            = 1'b0;
  logic        i_dir_rev        = 1'b0;
  logic        i_restart_on_err = 1'b1;
  logic [15:0] i_sc_half_div    = 16'h0028;
  logic [15:0] i_chop_period    = 16'h0020;
  logic [7:0]  i_duty           = 8'h80;
  logic [7:0]  i_duty_min       = 8'h33;
  logic [7:0]  i_duty_max       = 8'he6;
  logic [7:0]  i_duty_start     = 8'h66;
  logic [23:0] i_step_start     = 24'h000040;
  logic [23:0] i_step_min       = 24'h000040;
  logic [23:0] i_accel          = 24'h000000;
  logic [23:0] i_hand_step      = 24'h000001;
  logic        inj_en           = 1'b0;
  logic [2:0]  inj_code         = 3'h0;
  logic [2:0]  hall;
  logic        o_sc_filter_clock;
  logic [2:0]  o_gate_hi;
  logic [2:0]  o_gate_lo;
  logic [1:0]  o_mode;
  logic        o_seq_err;
  logic [23:0] o_speed_period;
  logic        o_dir_meas_rev;
  logic        o_hall_valid;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          on_run = 0;
  int          last_run = 0;
  int          cur_pos = 7;
  int          pos_q [$];
  int          n;

  sbc_ctrl dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_run(i_run),
    .i_dir_rev(i_dir_rev), .i_restart_on_err(i_restart_on_err),
    .i_sc_half_div(i_sc_half_div), .i_chop_period(i_chop_period), .i_duty(i_duty),
    .i_duty_min(i_duty_min), .i_duty_max(i_duty_max), .i_duty_start(i_duty_start),
    .i_step_start(i_step_start), .i_step_min(i_step_min), .i_accel(i_accel),
    .i_hand_step(i_hand_step), .i_emulated_hall_out(hall),
    .o_sc_filter_clock(o_sc_filter_clock), .o_gate_hi(o_gate_hi), .o_gate_lo(o_gate_lo),
    .o_mode(o_mode), .o_seq_err(o_seq_err), .o_speed_period(o_speed_period),
    .o_dir_meas_rev(o_dir_meas_rev), .o_hall_valid(o_hall_valid));
  sbc_drv_model u_drv (.i_clk_sys(i_clk_sys), .i_gate_hi(o_gate_hi), .i_gate_lo(o_gate_lo),
    .i_inj_en(inj_en), .i_inj_code(inj_code), .o_emulated_hall_out(hall));

  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  function automatic int pos_of(input logic [2:0] hi, input logic [2:0] lo);
    pos_of = 7;
    for (int p = 0; p < 6; p++) begin
      if (hi === EHI[p] && lo === ELO[p]) begin
        pos_of = p;
      end
    end
  endfunction : pos_of

  // counts cycles up to the next toggle of the filter clock
  task automatic to_toggle(output int cnt);
    logic v;
    v = o_sc_filter_clock;
    cnt = 0;
    while (o_sc_filter_clock === v && cnt < 500) begin
      @(negedge i_clk_sys);
      cnt++;
    end
  endtask : to_toggle

  task automatic wait_mode(input logic [1:0] m, input int bound);
    int k;
    k = 0;
    while (o_mode !== m && k < bound) begin
      @(negedge i_clk_sys);
      k++;
    end
  endtask : wait_mode

  task automatic run_steps(input logic rev, input int cnt);
    int k;
    k = 0;
    pos_q.delete();
    cur_pos = 7;
    @(posedge i_clk_sys);
    i_dir_rev <= rev;
    i_run     <= 1'b1;
    while (pos_q.size() < cnt && k < 3000) begin
      @(negedge i_clk_sys);
      k++;
    end
  endtask : run_steps

  task automatic stop_motor();
    @(posedge i_clk_sys);
    i_run <= 1'b0;
    repeat (3) @(negedge i_clk_sys);
    check(o_mode === 2'h0 && o_gate_hi === 3'h0 && o_gate_lo === 3'h0, "not idle");
  endtask : stop_motor

  // ------------------------------------------------------------
  // gate monitor, runs every cycle
  // ------------------------------------------------------------
  always @(negedge i_clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      conclude();
    end
    if (!i_sys_rst) begin
      check((o_gate_hi != 3'h0) === (o_gate_lo != 3'h0), "gates not chopped together");
      if (o_gate_hi != 3'h0) begin
        on_run++;
        check(pos_of(o_gate_hi, o_gate_lo) != 7, "illegal gate pattern");
        if (pos_of(o_gate_hi, o_gate_lo) != cur_pos) begin
          cur_pos = pos_of(o_gate_hi, o_gate_lo);
          pos_q.push_back(cur_pos);
        end
      end else if (on_run != 0) begin
        last_run = on_run;
        on_run = 0;
      end
      check(on_run < CHOP, "coils never left open");
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(negedge i_clk_sys);
    check(o_mode === 2'h0 && o_gate_hi === 3'h0 && o_seq_err === 1'b0, "reset state");
    check(o_speed_period === 24'hffffff && o_hall_valid === 1'b0, "reset speed");
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk_sys);
      i_sc_half_div <= rows[i].div;
      repeat (3) to_toggle(n);
      check(n == rows[i].half, "filter clock half period");
    end
    run_steps(1'b0, 7);
    for (int k = 0; k < 7; k++) begin
      check(pos_q[k] == k % 6, "forward step order");
    end
    check(o_mode === 2'h1, "forced mode");
    stop_motor();
    run_steps(1'b1, 7);
    for (int k = 0; k < 7; k++) begin
      check(pos_q[k] == (6 - k % 6) % 6, "reverse step order");
    end
    stop_motor();
    @(posedge i_clk_sys);
    i_duty_start <= 8'hff;
    run_steps(1'b0, 2);
    repeat (200) @(negedge i_clk_sys);
    check(last_run == 28 || last_run == 29, "duty not clamped high");
    @(posedge i_clk_sys);
    i_duty_start <= 8'h00;
    repeat (200) @(negedge i_clk_sys);
    check(last_run == 6 || last_run == 7, "duty not clamped low");
    stop_motor();
    @(posedge i_clk_sys);
    i_duty_start <= 8'h66;
    i_step_start <= 24'h000080;
    i_step_min   <= 24'h000020;
    i_accel      <= 24'h000008;
    i_hand_step  <= 24'h000030;
    run_steps(1'b0, 1);
    wait_mode(2'h2, 3000);
    check(o_mode === 2'h2, "no handover");
    repeat (20) @(negedge i_clk_sys);
    check(o_hall_valid === 1'b1 && o_dir_meas_rev === 1'b0, "hall state");
    check(o_speed_period !== 24'hffffff, "speed not measured");
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk_sys);
      i_restart_on_err <= (i == 0);
      inj_code         <= (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : ~hall;
      inj_en           <= 1'b1;
      n = 0;
      while (o_seq_err !== 1'b1 && n < 8) begin
        @(negedge i_clk_sys);
        n++;
      end
      check(o_seq_err === 1'b1, "no sequence error");
      check(o_mode === 2'h1, "no fallback");
      @(negedge i_clk_sys);
      check(o_seq_err === 1'b0, "error not a pulse");
      repeat (5) @(negedge i_clk_sys);
      check(o_seq_err === 1'b0 && o_hall_valid === 1'b0, "illegal hall in forced");
      @(posedge i_clk_sys);
      inj_en <= 1'b0;
      wait_mode(2'h2, 3000);
      check(o_mode === 2'h2, "no return to feedback");
    end
    // reset while the motor runs in feedback must bring back the idle state
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(negedge i_clk_sys);
    check(o_mode === 2'h0 && o_gate_hi === 3'h0 && o_seq_err === 1'b0, "mid-run reset");
    check(o_speed_period === 24'hffffff && o_hall_valid === 1'b0, "mid-run reset speed");
    conclude();
  end
endmodule : sensorless_bldc_commutation_control_tb
`default_nettype wire
